// >>> uflow_regs.vh
// Register offsets, field positions and constants of the flow control UART.
`ifndef UFLOW_REGS_VH
`define UFLOW_REGS_VH
`define UF_A_DATA 4'h0
`define UF_A_IER 4'h1
`define UF_A_ISR 4'h2
`define UF_A_LCR 4'h3
`define UF_A_MCR 4'h4
`define UF_A_EFR 4'h5
`define UF_A_XON1 4'h6
`define UF_A_XON2 4'h7
`define UF_A_XOFF1 4'h8
`define UF_A_XOFF2 4'h9
`define UF_A_STAT 4'hA
`define UF_RST8 8'h00
`define UF_EFR_CTS 7
`define UF_EFR_RTS 6
`define UF_EFR_SPC 5
`define UF_EFR_UNLK 4
`define UF_EFR_TXM 3:2
`define UF_EFR_RXM 1:0
`define UF_IER_CTS 7
`define UF_IER_RTS 6
`define UF_IER_SW 5
`define UF_IER_HI 7:4
`define UF_IER_RXT 0
`define UF_MCR_IR 6
`define UF_MCR_INV 2
`define UF_MCR_RTS 1
`define UF_FCR_TRIG 7:6
`define UF_LCR_WL 1:0
`define UF_SW_OFF 2'h0
`define UF_SW_ONE 2'h1
`define UF_SW_TWO 2'h2
`define UF_TRIG_1 5'h01
`define UF_TRIG_4 5'h04
`define UF_TRIG_8 5'h08
`define UF_TRIG_14 5'h0E
`define UF_FULL 5'h10
`define UF_EMPTY 5'h00
`define UF_WL_BASE 4'h5
`define UF_PH_MID 4'h7
`define UF_PH_LAST 4'hF
`define UF_IR_WIDTH 4'h3
`define UF_TWO_CHAR_SHIFT 5'h00
`endif

// >>> uflow_tx.v
// Transmit serializer with optional infrared pulse encoding.
`timescale 1ns/100ps
`include "uflow_regs.vh"
module uflow_tx (
  input wire core_clk,
  input wire resetn,
  input wire tick,
  input wire start,
  input wire [7:0] data,
  input wire [1:0] wl_sel,
  input wire irda,
  output reg busy,
  output reg txd
);
  reg [9:0] sh_r;
  reg [3:0] nb_r;
  reg [3:0] ph_r;
  wire [3:0] wl = {2'b00, wl_sel} + `UF_WL_BASE;
  wire [7:0] keep = 8'hFF >> (4'h8 - wl);

  always @(posedge core_clk) begin
    if (!resetn) begin
      busy <= 1'b0;
      sh_r <= 10'h3FF;
      nb_r <= 4'h0;
      ph_r <= 4'h0;
      txd <= 1'b1;
    end else begin
      if (start && !busy) begin
        // Bits above the word length read as one, so the stop bit lands
        // right after the last data bit.
        sh_r <= {1'b1, data | ~keep, 1'b0};
        nb_r <= wl + 4'h2;
        ph_r <= 4'h0;
        busy <= 1'b1;
      end else if (busy && tick) begin
        ph_r <= ph_r + 4'h1;
        if (ph_r == `UF_PH_LAST) begin
          sh_r <= {1'b1, sh_r[9:1]};
          nb_r <= nb_r - 4'h1;
          if (nb_r == 4'h1)
            busy <= 1'b0;
        end
      end
      if (irda)
        txd <= busy && !sh_r[0] && (ph_r < `UF_IR_WIDTH);
      else
        txd <= busy ? sh_r[0] : 1'b1;
    end
  end
endmodule // uflow_tx

// >>> uflow_rx.v
// Receive deserializer with optional infrared decoding and, in infrared mode only, polarity invert.
`timescale 1ns/100ps
`include "uflow_regs.vh"
module uflow_rx (
  input wire core_clk,
  input wire resetn,
  input wire tick,
  input wire rxd,
  input wire [1:0] wl_sel,
  input wire irda,
  input wire inv,
  output reg valid,
  output reg [7:0] data
);
  reg act_r;
  reg [3:0] ph_r;
  reg [3:0] bn_r;
  reg acc_r;
  reg [7:0] sh_r;
  wire [3:0] wl = {2'b00, wl_sel} + `UF_WL_BASE;
  wire line = irda ? (rxd ^ inv) : rxd;
  // High while the line shows a zero bit: a pulse in infrared mode.
  wire zb = irda ? line : ~line;
  wire cap = irda ? (ph_r == `UF_PH_LAST) : (ph_r == `UF_PH_MID);
  // The sample taken at the decision tick already belongs to the next bit,
  // so only the pulses gathered over the bit itself decide its value.
  wire bitv = irda ? ~acc_r : ~zb;

  always @(posedge core_clk) begin
    if (!resetn) begin
      act_r <= 1'b0;
      ph_r <= 4'h0;
      bn_r <= 4'h0;
      acc_r <= 1'b0;
      sh_r <= `UF_RST8;
      valid <= 1'b0;
      data <= `UF_RST8;
    end else begin
      valid <= 1'b0;
      if (tick) begin
        if (!act_r) begin
          if (zb) begin
            act_r <= 1'b1;
            ph_r <= 4'h0;
            bn_r <= 4'h0;
            acc_r <= 1'b0;
          end
        end else begin
          ph_r <= ph_r + 4'h1;
          acc_r <= (ph_r == `UF_PH_LAST) ? 1'b0 : (acc_r | zb);
          if (cap) begin
            if (bn_r == 4'h0) begin
              if (bitv)
                act_r <= 1'b0;
            end else if (bn_r <= wl) begin
              sh_r <= {bitv, sh_r[7:1]};
            end else begin
              valid <= 1'b1;
              data <= sh_r >> (4'h8 - wl);
              act_r <= 1'b0;
            end
            bn_r <= bn_r + 4'h1;
          end
        end
      end
    end
  end
endmodule // uflow_rx

// >>> uflow_top.v
// Flow control UART core: registers, receive FIFO, RTS/CTS and Xon/Xoff.
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/100ps
`include "uflow_regs.vh"
module uflow_top #(
  parameter DEPTH = 16,
  parameter AW = 4,
  parameter [15:0] DIV16 = 16'h0001
) (
  input wire core_clk,
  input wire resetn,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire serial_in,
  output wire serial_out,
  input wire cts_n,
  output reg rts_n,
  output reg irq
);
  function [4:0] trig_at;
    input [1:0] s;
    case (s)
      2'h0: trig_at = `UF_TRIG_1;
      2'h1: trig_at = `UF_TRIG_4;
      2'h2: trig_at = `UF_TRIG_8;
      default: trig_at = `UF_TRIG_14;
    endcase
  endfunction

  function [4:0] trig_up;
    input [1:0] s;
    case (s)
      2'h0: trig_up = `UF_TRIG_4;
      2'h1: trig_up = `UF_TRIG_8;
      2'h2: trig_up = `UF_TRIG_14;
      default: trig_up = `UF_FULL;
    endcase
  endfunction

  function [4:0] trig_dn;
    input [1:0] s;
    case (s)
      2'h0: trig_dn = `UF_EMPTY;
      2'h1: trig_dn = `UF_TRIG_1;
      2'h2: trig_dn = `UF_TRIG_4;
      default: trig_dn = `UF_TRIG_8;
    endcase
  endfunction

  function same;
    input [7:0] a;
    input [7:0] b;
    input [1:0] w;
    reg [7:0] m;
    begin
      m = 8'hFF >> (2'h3 - w);
      same = ((a ^ b) & m) == 8'h00;
    end
  endfunction

  reg [7:0] ier_r, lcr_r, mcr_r, efr_r, fcr_r;
  reg [7:0] xon1_r, xon2_r, xoff1_r, xoff2_r;
  reg [7:0] rxf_mem [0:DEPTH-1];
  reg [AW-1:0] wp_r, rp_r;
  reg [AW:0] cnt_r;
  reg [15:0] div_r;
  reg tick_r;
  reg [7:0] thr_r;
  reg thr_v_r;
  reg proc_v_r, pend_v_r, pend_off_r, sw_halt_r;
  reg [7:0] proc_d_r, pend_d_r;
  reg isr_fc_r, spc_r, rts_off_r, cts_q_r;
  reg timing_r, off_sent_r, fc_off_r, fc_sec_r;
  reg [1:0] fc_left_r;
  reg [8:0] timer_r;
  wire tx_busy, rx_v;
  wire [7:0] rx_byte;

  wire irda = mcr_r[`UF_MCR_IR];
  wire [1:0] wsel = lcr_r[`UF_LCR_WL];
  wire [1:0] tsel = fcr_r[`UF_FCR_TRIG];
  wire [1:0] rxm = efr_r[`UF_EFR_RXM];
  wire [1:0] txm = efr_r[`UF_EFR_TXM];
  wire [4:0] fill = cnt_r;
  wire full = fill == `UF_FULL;
  wire rx_trig = fill >= trig_at(tsel);
  wire pop = reg_rd && (reg_addr == `UF_A_DATA) && (fill != `UF_EMPTY);
  wire isr_rd = reg_rd && (reg_addr == `UF_A_ISR);
  wire cts_block = efr_r[`UF_EFR_CTS] && cts_n;
  wire [3:0] wl2 = {2'b00, wsel} + `UF_WL_BASE + 4'h2;

  // Receive character classification.
  wire m_on1 = same(proc_d_r, xon1_r, wsel);
  wire m_on2 = same(proc_d_r, xon2_r, wsel);
  wire m_off1 = same(proc_d_r, xoff1_r, wsel);
  wire m_off2 = same(proc_d_r, xoff2_r, wsel);
  reg fifo_we, keep_proc, pend_set, pend_clr, set_halt, clr_halt, spc_hit;
  reg [7:0] fifo_wd;

  always @* begin
    fifo_we = 1'b0;
    fifo_wd = proc_d_r;
    keep_proc = 1'b0;
    pend_set = 1'b0;
    pend_clr = 1'b0;
    set_halt = 1'b0;
    clr_halt = 1'b0;
    spc_hit = 1'b0;
    if (proc_v_r) begin
      if (pend_v_r) begin
        pend_clr = 1'b1;
        if (pend_off_r ? m_off2 : m_on2) begin
          set_halt = pend_off_r;
          clr_halt = !pend_off_r;
        end else begin
          // The held first character was ordinary data after all; store it
          // now and look at the current one again next cycle.
          fifo_we = !full;
          fifo_wd = pend_d_r;
          keep_proc = 1'b1;
        end
      end else if ((rxm == `UF_SW_TWO) && (m_off1 || m_on1)) begin
        pend_set = 1'b1;
      end else if ((rxm == `UF_SW_ONE) && m_off1) begin
        set_halt = 1'b1;
      end else if ((rxm == `UF_SW_ONE) && m_on1) begin
        clr_halt = 1'b1;
      end else begin
        fifo_we = !full;
        spc_hit = efr_r[`UF_EFR_SPC] && m_off2;
      end
    end
  end

  // Transmit arbitration: flow characters go ahead of host data.
  reg tx_go;
  reg [7:0] tx_data;
  always @* begin
    tx_go = 1'b0;
    if (fc_off_r)
      tx_data = fc_sec_r ? xoff2_r : xoff1_r;
    else
      tx_data = fc_sec_r ? xon2_r : xon1_r;
    if (!tx_busy) begin
      if (fc_left_r != 2'h0) begin
        tx_go = 1'b1;
      end else if (thr_v_r && !sw_halt_r && !cts_block) begin
        tx_go = 1'b1;
        tx_data = thr_r;
      end
    end
  end

  wire rts_auto = efr_r[`UF_EFR_RTS] && mcr_r[`UF_MCR_RTS];
  wire rts_nxt = rts_auto ? rts_off_r : ~mcr_r[`UF_MCR_RTS];
  wire [4:0] up = trig_up(tsel);
  wire [4:0] dn = trig_dn(tsel);

  always @(posedge core_clk) begin
    if (!resetn) begin
      ier_r <= `UF_RST8;
      lcr_r <= `UF_RST8;
      mcr_r <= `UF_RST8;
      efr_r <= `UF_RST8;
      fcr_r <= `UF_RST8;
      xon1_r <= `UF_RST8;
      xon2_r <= `UF_RST8;
      xoff1_r <= `UF_RST8;
      xoff2_r <= `UF_RST8;
      thr_r <= `UF_RST8;
      thr_v_r <= 1'b0;
    end else begin
      if (tx_go && (fc_left_r == 2'h0))
        thr_v_r <= 1'b0;
      if (reg_wr) begin
        if (reg_addr == `UF_A_DATA) begin
          thr_r <= reg_wdata;
          thr_v_r <= 1'b1;
        end else if (reg_addr == `UF_A_IER) begin
          ier_r[3:0] <= reg_wdata[3:0];
          if (efr_r[`UF_EFR_UNLK])
            ier_r[`UF_IER_HI] <= reg_wdata[`UF_IER_HI];
        end else if (reg_addr == `UF_A_ISR) begin
          fcr_r <= reg_wdata;
        end else if (reg_addr == `UF_A_LCR) begin
          lcr_r <= reg_wdata;
        end else if (reg_addr == `UF_A_MCR) begin
          mcr_r <= reg_wdata;
        end else if (reg_addr == `UF_A_EFR) begin
          efr_r <= reg_wdata;
        end else if (reg_addr == `UF_A_XON1) begin
          xon1_r <= reg_wdata;
        end else if (reg_addr == `UF_A_XON2) begin
          xon2_r <= reg_wdata;
        end else if (reg_addr == `UF_A_XOFF1) begin
          xoff1_r <= reg_wdata;
        end else if (reg_addr == `UF_A_XOFF2) begin
          xoff2_r <= reg_wdata;
        end
      end
    end
  end

  always @(posedge core_clk) begin
    if (fifo_we)
      rxf_mem[wp_r] <= fifo_wd;
  end

  always @(posedge core_clk) begin
    if (!resetn) begin
      div_r <= 16'h0000;
      tick_r <= 1'b0;
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
      proc_v_r <= 1'b0;
      proc_d_r <= `UF_RST8;
      pend_v_r <= 1'b0;
      pend_off_r <= 1'b0;
      pend_d_r <= `UF_RST8;
      sw_halt_r <= 1'b0;
      spc_r <= 1'b0;
      isr_fc_r <= 1'b0;
      rts_off_r <= 1'b0;
      rts_n <= 1'b1;
      cts_q_r <= 1'b0;
      irq <= 1'b0;
      reg_rdata <= `UF_RST8;
    end else begin
      tick_r <= (div_r == DIV16 - 16'h0001);
      div_r <= (div_r == DIV16 - 16'h0001) ? 16'h0000 : div_r + 16'h0001;
      if (fifo_we)
        wp_r <= wp_r + 1'b1;
      if (pop)
        rp_r <= rp_r + 1'b1;
      if (fifo_we && !pop)
        cnt_r <= cnt_r + 1'b1;
      else if (pop && !fifo_we)
        cnt_r <= cnt_r - 1'b1;
      proc_v_r <= rx_v || keep_proc;
      if (rx_v)
        proc_d_r <= rx_byte;
      if (pend_set) begin
        pend_v_r <= 1'b1;
        pend_off_r <= m_off1;
        pend_d_r <= proc_d_r;
      end else if (pend_clr) begin
        pend_v_r <= 1'b0;
      end
      if (set_halt)
        sw_halt_r <= 1'b1;
      else if (clr_halt)
        sw_halt_r <= 1'b0;
      if (spc_hit)
        spc_r <= 1'b1;
      else if (isr_rd)
        spc_r <= 1'b0;
      if (fill >= up)
        rts_off_r <= 1'b1;
      else if (fill <= dn)
        rts_off_r <= 1'b0;
      rts_n <= rts_nxt;
      cts_q_r <= cts_n;
      // A new event in the reading cycle wins over the clear.
      if ((ier_r[`UF_IER_RTS] && rts_nxt && !rts_n) ||
          (ier_r[`UF_IER_CTS] && cts_n && !cts_q_r))
        isr_fc_r <= 1'b1;
      else if (isr_rd)
        isr_fc_r <= 1'b0;
      irq <= isr_fc_r || (ier_r[`UF_IER_SW] && (sw_halt_r || spc_r)) ||
             (ier_r[`UF_IER_RXT] && rx_trig);
      reg_rdata <= `UF_RST8;
      if (reg_rd) begin
        if (reg_addr == `UF_A_DATA)
          reg_rdata <= (fill != `UF_EMPTY) ? rxf_mem[rp_r] : `UF_RST8;
        else if (reg_addr == `UF_A_IER)
          reg_rdata <= ier_r;
        else if (reg_addr == `UF_A_ISR)
          reg_rdata <= {2'b00, isr_fc_r, sw_halt_r | spc_r, 3'b000, rx_trig};
        else if (reg_addr == `UF_A_LCR)
          reg_rdata <= lcr_r;
        else if (reg_addr == `UF_A_MCR)
          reg_rdata <= mcr_r;
        else if (reg_addr == `UF_A_EFR)
          reg_rdata <= efr_r;
        else if (reg_addr == `UF_A_XON1)
          reg_rdata <= xon1_r;
        else if (reg_addr == `UF_A_XON2)
          reg_rdata <= xon2_r;
        else if (reg_addr == `UF_A_XOFF1)
          reg_rdata <= xoff1_r;
        else if (reg_addr == `UF_A_XOFF2)
          reg_rdata <= xoff2_r;
        else if (reg_addr == `UF_A_STAT)
          reg_rdata <= {sw_halt_r, rts_off_r, off_sent_r, fill};
      end
    end
  end

  // Automatic Xoff/Xon sending on receive FIFO level.
  always @(posedge core_clk) begin
    if (!resetn) begin
      timing_r <= 1'b0;
      timer_r <= 9'h000;
      off_sent_r <= 1'b0;
      fc_left_r <= 2'h0;
      fc_off_r <= 1'b0;
      fc_sec_r <= 1'b0;
    end else begin
      if (tx_go && (fc_left_r != 2'h0)) begin
        fc_left_r <= fc_left_r - 2'h1;
        fc_sec_r <= 1'b1;
      end
      if (txm == `UF_SW_OFF) begin
        timing_r <= 1'b0;
        off_sent_r <= 1'b0;
      end else if (timing_r) begin
        if (tick_r)
          timer_r <= timer_r - 9'h001;
        if (timer_r == 9'h000) begin
          timing_r <= 1'b0;
          off_sent_r <= 1'b1;
          fc_off_r <= 1'b1;
          fc_sec_r <= 1'b0;
          fc_left_r <= (txm == `UF_SW_TWO) ? 2'h2 : 2'h1;
        end
      end else if (!off_sent_r && rx_trig) begin
        // Two character times counted in 16x ticks.
        timing_r <= 1'b1;
        timer_r <= {wl2, `UF_TWO_CHAR_SHIFT};
      end else if (off_sent_r && (fill <= dn) && (fc_left_r == 2'h0)) begin
        off_sent_r <= 1'b0;
        fc_off_r <= 1'b0;
        fc_sec_r <= 1'b0;
        fc_left_r <= (txm == `UF_SW_TWO) ? 2'h2 : 2'h1;
      end
    end
  end

  uflow_tx u_tx (
    .core_clk(core_clk),
    .resetn(resetn),
    .tick(tick_r),
    .start(tx_go),
    .data(tx_data),
    .wl_sel(wsel),
    .irda(irda),
    .busy(tx_busy),
    .txd(serial_out)
  );

  uflow_rx u_rx (
    .core_clk(core_clk),
    .resetn(resetn),
    .tick(tick_r),
    .rxd(serial_in),
    .wl_sel(wsel),
    .irda(irda),
    .inv(mcr_r[`UF_MCR_INV]),
    .valid(rx_v),
    .data(rx_byte)
  );
endmodule // uflow_top

// >>> uflow_top_properties.sv
// Port-level assertions for the flow control UART core.
`timescale 1ns/100ps
`include "uflow_regs.vh"
module uflow_checker #(
  parameter [15:0] DIV16 = 16'h0001
) (
  input logic core_clk,
  input logic resetn,
  input logic [3:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input logic [7:0] reg_rdata,
  input logic serial_in,
  input logic serial_out,
  input logic cts_n,
  input logic rts_n,
  input logic irq
);
  logic [7:0] modem_r, feat_r, ien_r, high_r;
  // Shadows of the MCR, EFR and IER registers, rebuilt from bus writes.
  always @(posedge core_clk) begin
    if (!resetn) begin
      modem_r <= 8'h00;
      feat_r <= 8'h00;
      ien_r <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == `UF_A_MCR)
        modem_r <= reg_wdata;
      if (reg_addr == `UF_A_EFR)
        feat_r <= reg_wdata;
      if (reg_addr == `UF_A_IER)
        ien_r <= {feat_r[4] ? reg_wdata[7:4] : ien_r[7:4], reg_wdata[3:0]};
    end
  end
  // Earlier consecutive high samples of the transmit line, saturating.
  always @(posedge core_clk) begin
    if (!resetn || !serial_out)
      high_r <= 8'h00;
    else if (high_r != 8'hFF)
      high_r <= high_r + 8'h01;
  end
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_irq_soon;
    ##[1:4] irq;
  endsequence
  // Pulse width in clocks holds only while one clock makes one 16x tick.
  sequence s_ir_tail;
    serial_out [*2] ##1 !serial_out;
  endsequence
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside the answer cycle");
  a_reset_vals: assert property (@(posedge core_clk) disable iff (1'b0)
    !resetn |=> rts_n && !irq && reg_rdata == 8'h00)
    else $error("outputs not at rest after reset");
  a_rts_manual: assert property (
    !feat_r[6] && $stable(modem_r) && $stable(feat_r) |-> rts_n == !modem_r[1])
    else $error("rts pin does not follow the manual bit");
  a_rts_event: assert property (
    ien_r[6] && $rose(rts_n) |-> s_irq_soon)
    else $error("rts rise gave no interrupt");
  a_cts_event: assert property (
    ien_r[7] && $rose(cts_n) |-> s_irq_soon)
    else $error("cts release gave no interrupt");
  a_cts_hold: assert property (
    (feat_r[7] && feat_r[3:2] == 2'b00 && !modem_r[6] && cts_n &&
     high_r > 8'hAA) [*6] |-> serial_out)
    else $error("frame started while cts was high");
  a_ir_pulse: assert property (
    modem_r[6] && $rose(serial_out) |=> s_ir_tail)
    else $error("infrared pulse has the wrong width");
  a_ir_idle: assert property (
    modem_r[6] && $past(modem_r[6], 4) |-> high_r <= 8'h03)
    else $error("infrared line not idling low");
endmodule // uflow_checker

// >>> uflow_peer.sv
// Remote serial partner: frame sender and NRZ frame collector.
`timescale 1ns/100ps
module uflow_peer (
  input logic core_clk,
  input logic rx_line,
  output logic tx_line
);
  logic [7:0] got_q[$];
  logic [7:0] b_r;
  logic ir_r;
  logic inv_r;
  int j;
  initial begin
    ir_r = 1'b0;
    inv_r = 1'b0;
    tx_line = 1'b1;
  end
  task automatic set_mode(input logic ir, input logic inv);
    ir_r = ir;
    inv_r = inv;
    @(posedge core_clk);
    tx_line <= !ir | inv;
  endtask
  // Ignores rts on purpose, so the core must cope with an eager sender.
  task automatic send(input logic [7:0] d, input int nb);
    logic bv;
    int i;
    int k;
    for (i = 0; i < nb + 2; i++) begin
      bv = (i == 0) ? 1'b0 : (i > nb) ? 1'b1 : d[i-1];
      for (k = 0; k < 16; k++) begin
        @(posedge core_clk);
        tx_line <= ir_r ? inv_r ^ (!bv && k < 3) : bv;
      end
    end
  endtask
  // Infrared output is judged by the bench, so only NRZ is collected.
  initial forever begin
    @(posedge core_clk);
    if (!ir_r && rx_line === 1'b0) begin
      repeat (8) @(posedge core_clk);
      for (j = 0; j < 8; j++) begin
        repeat (16) @(posedge core_clk);
        b_r[j] = rx_line;
      end
      repeat (16) @(posedge core_clk);
      got_q.push_back(b_r);
    end
  end
endmodule // uflow_peer

// >>> uflow_top_tb.sv
// Self-checking bench for the flow control UART core.
`timescale 1ns/100ps
`include "uflow_regs.vh"
module uflow_top_tb;
  logic core_clk, resetn, reg_wr, reg_rd, cts_n, irq, rts_n;
  logic serial_in, serial_out;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  int err_count, cmp_count;
  uflow_top #(.DIV16(16'h0001)) uflow_top_inst (.core_clk(core_clk),
    .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_in(serial_in), .serial_out(serial_out), .cts_n(cts_n),
    .rts_n(rts_n), .irq(irq));
  uflow_peer uflow_peer_inst (.core_clk(core_clk), .rx_line(serial_out),
    .tx_line(serial_in));
  always #50 core_clk = ~core_clk;
  task automatic end_sim();
    $display("mismatches %0d of %0d compares", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input string n, input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(n, reg_rdata, e);
  endtask
  function automatic logic [7:0] qn();
    return 8'(uflow_peer_inst.got_q.size());
  endfunction
  task automatic get(output logic [7:0] v);
    int n;
    v = 8'hXX;
    for (n = 0; n < 700 && qn() == 8'h00; n++)
      wt(1);
    if (qn() != 8'h00)
      v = uflow_peer_inst.got_q.pop_front();
  endtask
  task automatic rst();
    @(posedge core_clk);
    resetn <= 1'b0;
    cts_n <= 1'b0;
    uflow_peer_inst.set_mode(1'b0, 1'b0);
    wt(4);
    resetn <= 1'b1;
    uflow_peer_inst.got_q.delete();
    wr(`UF_A_LCR, 8'h03);
  endtask
  task automatic t_regs();
    logic [7:0] a;
    rst();
    for (a = 8'h06; a <= 8'h09; a++)
      rdc("flow_char", a[3:0], 8'h00);
    rdc("unmapped", 4'hB, 8'h00);
    wr(`UF_A_XON2, 8'hC3);
    rdc("xon2", `UF_A_XON2, 8'hC3);
    wr(`UF_A_MCR, 8'h02);
    wt(3);
    chk("rts_on", rts_n, 1'b0);
    wr(`UF_A_EFR, 8'h10);
    wr(`UF_A_IER, 8'h40);
    wr(`UF_A_MCR, 8'h00);
    wt(4);
    chk("rts_irq", irq, 1'b1);
    rdc("rts_flag", `UF_A_ISR, 8'h20);
  endtask
  task automatic t_auto_rts();
    int i;
    rst();
    wr(`UF_A_EFR, 8'h40);
    wr(`UF_A_IER, 8'h01);
    wr(`UF_A_ISR, 8'h40);
    wr(`UF_A_MCR, 8'h02);
    for (i = 1; i <= 17; i++) begin
      uflow_peer_inst.send(8'h30 + i[7:0], 8);
      wt(4);
      if (i <= 4)
        chk("rx_irq", irq, i == 4);
      if (i == 7 || i == 8)
        chk("rts_hyst", rts_n, i == 8);
    end
    rdc("fill", `UF_A_STAT, 8'h50);
    for (i = 1; i <= 15; i++) begin
      rdc("rx_data", `UF_A_DATA, 8'h30 + i[7:0]);
      wt(3);
      chk("rts_back", rts_n, i < 15);
    end
  endtask
  task automatic t_cts();
    logic [7:0] v;
    rst();
    wr(`UF_A_EFR, 8'h90);
    wr(`UF_A_IER, 8'h80);
    cts_n <= 1'b1;
    wt(5);
    chk("cts_irq", irq, 1'b1);
    wr(`UF_A_DATA, 8'h55);
    wt(400);
    chk("cts_hold", qn(), 8'h00);
    cts_n <= 1'b0;
    get(v);
    chk("cts_resume", v, 8'h55);
    wr(`UF_A_DATA, 8'hA5);
    wt(40);
    cts_n <= 1'b1;
    wr(`UF_A_DATA, 8'h3C);
    get(v);
    chk("cts_finish", v, 8'hA5);
    wt(300);
    chk("cts_stop", qn(), 8'h00);
    cts_n <= 1'b0;
    get(v);
    chk("cts_next", v, 8'h3C);
  endtask
  task automatic t_swflow();
    logic [7:0] v;
    rst();
    wr(`UF_A_LCR, 8'h02);
    wr(`UF_A_EFR, 8'h12);
    wr(`UF_A_IER, 8'h20);
    wr(`UF_A_XOFF1, 8'h93);
    wr(`UF_A_XOFF2, 8'h94);
    wr(`UF_A_XON1, 8'h91);
    wr(`UF_A_XON2, 8'h92);
    uflow_peer_inst.send(8'h13, 7);
    rdc("half_pair", `UF_A_STAT, 8'h00);
    uflow_peer_inst.send(8'h14, 7);
    wt(4);
    chk("sw_irq", irq, 1'b1);
    rdc("halted", `UF_A_STAT, 8'h80);
    wr(`UF_A_DATA, 8'h41);
    wt(400);
    chk("sw_hold", qn(), 8'h00);
    uflow_peer_inst.send(8'h11, 7);
    uflow_peer_inst.send(8'h12, 7);
    get(v);
    // Seven-bit frames: the collector reads the stop bit as bit 7.
    chk("sw_resume", v, 8'hC1);
    rdc("resumed", `UF_A_STAT, 8'h00);
  endtask
  task automatic t_special();
    rst();
    wr(`UF_A_EFR, 8'h31);
    wr(`UF_A_IER, 8'h20);
    wr(`UF_A_XOFF2, 8'h7E);
    wr(`UF_A_XOFF1, 8'h24);
    uflow_peer_inst.send(8'h7E, 8);
    wt(4);
    chk("spc_irq", irq, 1'b1);
    rdc("spc_flag", `UF_A_ISR, 8'h11);
    rdc("spc_data", `UF_A_DATA, 8'h7E);
    uflow_peer_inst.send(8'h24, 8);
    wt(4);
    rdc("single_off", `UF_A_STAT, 8'h80);
  endtask
  task automatic t_autosend();
    logic [7:0] v;
    rst();
    wr(`UF_A_EFR, 8'h04);
    wr(`UF_A_XOFF1, 8'h13);
    wr(`UF_A_XON1, 8'h11);
    uflow_peer_inst.send(8'h55, 8);
    wt(250);
    chk("xoff_wait", qn(), 8'h00);
    get(v);
    chk("xoff_sent", v, 8'h13);
    rdc("xoff_data", `UF_A_DATA, 8'h55);
    get(v);
    chk("xon_sent", v, 8'h11);
  endtask
  task automatic t_irda();
    int i;
    int n;
    rst();
    uflow_peer_inst.set_mode(1'b1, 1'b1);
    wr(`UF_A_MCR, 8'h44);
    wt(4);
    chk("ir_idle", serial_out, 1'b0);
    wr(`UF_A_DATA, 8'h00);
    n = 0;
    for (i = 0; i < 200; i++) begin
      wt(1);
      n += serial_out;
    end
    chk("ir_pulses", n[7:0], 8'h1B);
    uflow_peer_inst.send(8'h5A, 8);
    wt(8);
    rdc("ir_rx", `UF_A_DATA, 8'h5A);
  endtask
  initial begin
    core_clk = 1'b0;
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    cts_n = 1'b0;
    err_count = 0;
    cmp_count = 0;
    t_regs();
    t_auto_rts();
    t_cts();
    t_swflow();
    t_special();
    t_autosend();
    t_irda();
    end_sim();
  end
  initial begin
    #2000000;
    err_count++;
    end_sim();
  end
endmodule // uflow_top_tb
bind uflow_top uflow_checker #(.DIV16(DIV16)) uflow_checker_inst (
  .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .serial_in(serial_in), .serial_out(serial_out),
  .cts_n(cts_n), .rts_n(rts_n), .irq(irq));
